// [verilog/gecf_defs.vh]
// Register offsets, field positions and reset values of the guest execution-control bank
`ifndef GECF_DEFS_VH
`define GECF_DEFS_VH
`define GECF_OFF_ROOT_LO 12'h000
`define GECF_OFF_ROOT_HI 12'h004
`define GECF_OFF_TAG 12'h008
`define GECF_OFF_GAP 12'h00c
`define GECF_OFF_WIN 12'h010
`define GECF_OFF_FUNC_LO 12'h014
`define GECF_OFF_FUNC_HI 12'h018
`define GECF_OFF_LIST_LO 12'h01c
`define GECF_OFF_LIST_HI 12'h020
`define GECF_OFF_RDBM_LO 12'h024
`define GECF_OFF_RDBM_HI 12'h028
`define GECF_OFF_WRBM_LO 12'h02c
`define GECF_OFF_WRBM_HI 12'h030
`define GECF_OFF_FINFO_LO 12'h034
`define GECF_OFF_FINFO_HI 12'h038
`define GECF_OFF_INDEX 12'h03c
`define GECF_OFF_SSX_LO 12'h040
`define GECF_OFF_SSX_HI 12'h044
`define GECF_OFF_STATUS 12'h048
`define GECF_OFF_MASK 12'h04c
`define GECF_OFF_TIMER 12'h050
`define GECF_OFF_CTRL 12'h054
`define GECF_MT_LSB 0
`define GECF_MT_MSB 2
`define GECF_WALK_LSB 3
`define GECF_WALK_MSB 5
`define GECF_AD_BIT 6
`define GECF_RSV_LSB 7
`define GECF_RSV_MSB 11
`define GECF_ADDR_LSB 12
`define GECF_MT_UNCACHED 3'h0
`define GECF_MT_WRITEBACK 3'h6
`define GECF_FUNC_SWITCH_BIT 0
`define GECF_LIST_ENTRIES 512
`define GECF_LIST_IDX_W 9
`define GECF_BITMAP_BITS 32768
`define GECF_BITMAP_IDX_W 15
`define GECF_NUM_EVT 4
`define GECF_EVT_GAP 0
`define GECF_EVT_WIN 1
`define GECF_EVT_SWITCH 2
`define GECF_EVT_BADROOT 3
`define GECF_RST_ZERO 32'h0000_0000
`endif

// [verilog/gecf_bank.v]
// Guest execution-control field bank with AHB-Lite register access
// What this block does
// [R1] Root bits 2:0 pick uncached or writeback type
// [R2] Walk levels equal root bits 5:3 plus one
// [R3] Root bit 6 enables accessed/dirty flag upkeep
// [R4] Table address from bits N-1:12, rest reserved
// [R5] Root field exists only with translation support
// [R6] Sixteen-bit processor tag, only if tagging supported
// [R7] Thirty-two-bit gap limit between spin hints
// [R8] Thirty-two-bit window limit for one loop
// [R9] Limits compared to timestamp-rate counter
// [R10] Function vector bit 0 enables pointer switching
// [R11] Reserved function bits set block guest entry
// [R12] Pointer list: 512 eight-byte entries in page
// [R13] Shadow bitmaps 32 Kbit, used only when shadowing
// [R14] Fault info stored at fault address
// [R15] Fault copies sixteen-bit pointer index (here only on faults with vfault_nested set)
// [R16] Switching updates index to selected entry
// [R17] Save bitmap consulted only when control enabled
// [R18] Bad root type or reserved bits flagged invalid
`include "gecf_defs.vh"
module gecf_bank #(
    parameter PA_WIDTH = 52,
    parameter HAS_NESTED = 1,
    parameter HAS_TAG = 1
) (
    // Clock, reset, enable
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Timestamp-rate tick and spin hints
    input wire ts_tick,
    input wire spin_hint,
    // Pointer switching request
    input wire switch_req,
    input wire [8:0] switch_idx,
    // Shadow bitmap and save bitmap lookups
    input wire shadowing_en,
    input wire [14:0] bitmap_idx,
    input wire ssave_en,
    input wire [5:0] ssave_idx,
    // Virtualization fault
    input wire vfault,
    input wire vfault_nested,
    // Decoded outputs
    output reg [2:0] mem_type,
    output reg [2:0] walk_levels,
    output reg ad_flags_en,
    output reg [63:0] top_table_addr,
    output reg [15:0] proc_tag,
    output reg root_invalid,
    output reg entry_fail,
    output reg switch_en,
    output reg [63:0] list_entry_addr,
    output reg [63:0] rd_bitmap_byte_addr,
    output reg [63:0] wr_bitmap_byte_addr,
    output reg [2:0] bitmap_bit,
    output reg bitmap_valid,
    output reg ssave_exit,
    output reg [63:0] finfo_addr,
    output reg [15:0] finfo_index,
    output reg finfo_write,
    output reg spin_exit,
    output reg irq
);
    // ****************************************
    // Storage
    // ****************************************
    reg [63:0] root_r;
    reg [15:0] tag_r;
    reg [31:0] gap_r;
    reg [31:0] win_r;
    reg [63:0] func_r;
    reg [63:0] list_r;
    reg [63:0] rdbm_r;
    reg [63:0] wrbm_r;
    reg [63:0] finfo_r;
    reg [15:0] index_r;
    reg [63:0] ssx_r;
    reg [3:0] status_r;
    reg [3:0] mask_r;
    reg [31:0] gap_cnt_r;
    reg [31:0] win_cnt_r;
    reg in_loop_r;
    reg ph_wr_r;
    reg ph_rd_r;
    reg [11:0] ph_addr_r;
    reg [3:0] evt;
    wire [63:0] root_rsv_mask;
    wire mt_ok;
    wire acc;
    wire wr_go;
    integer i;

    // ****************************************
    // Root pointer checks
    // ****************************************
    function [63:0] rsv_mask;
        input integer n;
        integer k;
        begin
            rsv_mask = 64'h0000_0000_0000_0000;
            for (k = 0; k < 64; k = k + 1) begin
                if ((k >= `GECF_RSV_LSB && k <= `GECF_RSV_MSB) || k >= n) begin
                    rsv_mask[k] = 1'b1;
                end
            end
        end
    endfunction

    function [31:0] pick32;
        input [63:0] v;
        input hi;
        begin
            pick32 = hi ? v[63:32] : v[31:0];
        end
    endfunction

    assign root_rsv_mask = rsv_mask(PA_WIDTH);
    assign mt_ok = (root_r[`GECF_MT_MSB:`GECF_MT_LSB] == `GECF_MT_UNCACHED) ||
                   (root_r[`GECF_MT_MSB:`GECF_MT_LSB] == `GECF_MT_WRITEBACK); // [R1]
    assign acc = hsel && hready && htrans[1];
    assign wr_go = ph_wr_r && clk_en;

    // ****************************************
    // Bus address phase and register writes
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
            ph_addr_r <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            root_r <= 64'h0000_0000_0000_0000;
            tag_r <= 16'h0000;
            gap_r <= `GECF_RST_ZERO;
            win_r <= `GECF_RST_ZERO;
            func_r <= 64'h0000_0000_0000_0000;
            list_r <= 64'h0000_0000_0000_0000;
            rdbm_r <= 64'h0000_0000_0000_0000;
            wrbm_r <= 64'h0000_0000_0000_0000;
            finfo_r <= 64'h0000_0000_0000_0000;
            index_r <= 16'h0000;
            ssx_r <= 64'h0000_0000_0000_0000;
            mask_r <= 4'h0;
        end else if (clk_en) begin
            ph_wr_r <= acc && hwrite;
            ph_rd_r <= acc && !hwrite;
            if (acc) begin
                ph_addr_r <= haddr;
            end
            if (switch_req && switch_en) begin
                index_r <= {7'h00, switch_idx}; // [R16]
            end
            if (wr_go) begin
                case (ph_addr_r)
                    `GECF_OFF_ROOT_LO: if (HAS_NESTED != 0) root_r[31:0] <= hwdata; // [R5]
                    `GECF_OFF_ROOT_HI: if (HAS_NESTED != 0) root_r[63:32] <= hwdata;
                    `GECF_OFF_TAG: if (HAS_TAG != 0) tag_r <= hwdata[15:0]; // [R6]
                    `GECF_OFF_GAP: gap_r <= hwdata; // [R7]
                    `GECF_OFF_WIN: win_r <= hwdata; // [R8]
                    `GECF_OFF_FUNC_LO: func_r[31:0] <= hwdata; // [R10]
                    `GECF_OFF_FUNC_HI: func_r[63:32] <= hwdata;
                    `GECF_OFF_LIST_LO: list_r[31:0] <= hwdata;
                    `GECF_OFF_LIST_HI: list_r[63:32] <= hwdata;
                    `GECF_OFF_RDBM_LO: rdbm_r[31:0] <= hwdata;
                    `GECF_OFF_RDBM_HI: rdbm_r[63:32] <= hwdata;
                    `GECF_OFF_WRBM_LO: wrbm_r[31:0] <= hwdata;
                    `GECF_OFF_WRBM_HI: wrbm_r[63:32] <= hwdata;
                    `GECF_OFF_FINFO_LO: finfo_r[31:0] <= hwdata;
                    `GECF_OFF_FINFO_HI: finfo_r[63:32] <= hwdata;
                    `GECF_OFF_INDEX: if (!(switch_req && switch_en)) index_r <= hwdata[15:0];
                    `GECF_OFF_SSX_LO: ssx_r[31:0] <= hwdata;
                    `GECF_OFF_SSX_HI: ssx_r[63:32] <= hwdata;
                    `GECF_OFF_MASK: mask_r <= hwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Read data and sticky status
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            status_r <= 4'h0;
        end else if (clk_en) begin
            hrdata <= 32'h0000_0000;
            if (acc && !hwrite) begin
                case (haddr)
                    `GECF_OFF_ROOT_LO: hrdata <= pick32(root_r, 1'b0);
                    `GECF_OFF_ROOT_HI: hrdata <= pick32(root_r, 1'b1);
                    `GECF_OFF_TAG: hrdata <= {16'h0000, tag_r};
                    `GECF_OFF_GAP: hrdata <= gap_r;
                    `GECF_OFF_WIN: hrdata <= win_r;
                    `GECF_OFF_FUNC_LO: hrdata <= pick32(func_r, 1'b0);
                    `GECF_OFF_FUNC_HI: hrdata <= pick32(func_r, 1'b1);
                    `GECF_OFF_LIST_LO: hrdata <= pick32(list_r, 1'b0);
                    `GECF_OFF_LIST_HI: hrdata <= pick32(list_r, 1'b1);
                    `GECF_OFF_RDBM_LO: hrdata <= pick32(rdbm_r, 1'b0);
                    `GECF_OFF_RDBM_HI: hrdata <= pick32(rdbm_r, 1'b1);
                    `GECF_OFF_WRBM_LO: hrdata <= pick32(wrbm_r, 1'b0);
                    `GECF_OFF_WRBM_HI: hrdata <= pick32(wrbm_r, 1'b1);
                    `GECF_OFF_FINFO_LO: hrdata <= pick32(finfo_r, 1'b0);
                    `GECF_OFF_FINFO_HI: hrdata <= pick32(finfo_r, 1'b1);
                    `GECF_OFF_INDEX: hrdata <= {16'h0000, index_r};
                    `GECF_OFF_SSX_LO: hrdata <= pick32(ssx_r, 1'b0);
                    `GECF_OFF_SSX_HI: hrdata <= pick32(ssx_r, 1'b1);
                    `GECF_OFF_STATUS: hrdata <= {28'h0000000, status_r};
                    `GECF_OFF_MASK: hrdata <= {28'h0000000, mask_r};
                    `GECF_OFF_TIMER: hrdata <= win_cnt_r;
                    `GECF_OFF_CTRL: hrdata <= {29'h00000000, entry_fail, root_invalid,
                                               in_loop_r};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
            // New events win over the read clear
            if (acc && !hwrite && haddr == `GECF_OFF_STATUS) begin
                status_r <= evt;
            end else begin
                status_r <= status_r | evt;
            end
        end
    end

    // ****************************************
    // Spin-loop timing
    // ****************************************
    always @* begin
        evt = 4'h0;
        evt[`GECF_EVT_GAP] = ts_tick && in_loop_r && !spin_hint && (gap_cnt_r >= gap_r);
        evt[`GECF_EVT_WIN] = ts_tick && in_loop_r && (win_cnt_r >= win_r); // [R8]
        evt[`GECF_EVT_SWITCH] = switch_req && switch_en;
        evt[`GECF_EVT_BADROOT] = wr_go && (ph_addr_r == `GECF_OFF_ROOT_LO ||
                                  ph_addr_r == `GECF_OFF_ROOT_HI);
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            gap_cnt_r <= `GECF_RST_ZERO;
            win_cnt_r <= `GECF_RST_ZERO;
            in_loop_r <= 1'b0;
            spin_exit <= 1'b0;
        end else if (clk_en) begin
            spin_exit <= evt[`GECF_EVT_WIN];
            if (spin_hint) begin
                gap_cnt_r <= `GECF_RST_ZERO;
                in_loop_r <= 1'b1;
                if (!in_loop_r) begin
                    win_cnt_r <= `GECF_RST_ZERO;
                end
            end else if (ts_tick && in_loop_r) begin // [R9]
                if (gap_cnt_r >= gap_r || win_cnt_r >= win_r) begin // [R7]
                    in_loop_r <= 1'b0;
                end
                gap_cnt_r <= gap_cnt_r + 32'h0000_0001;
            end
            // Window time runs on every tick inside the loop, hints included
            if (ts_tick && in_loop_r) begin // [R9]
                win_cnt_r <= win_cnt_r + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // Decoded outputs
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_type <= 3'h0;
            walk_levels <= 3'h1;
            ad_flags_en <= 1'b0;
            top_table_addr <= 64'h0000_0000_0000_0000;
            proc_tag <= 16'h0000;
            root_invalid <= 1'b0;
            entry_fail <= 1'b0;
            switch_en <= 1'b0;
            list_entry_addr <= 64'h0000_0000_0000_0000;
            rd_bitmap_byte_addr <= 64'h0000_0000_0000_0000;
            wr_bitmap_byte_addr <= 64'h0000_0000_0000_0000;
            bitmap_bit <= 3'h0;
            bitmap_valid <= 1'b0;
            ssave_exit <= 1'b0;
            finfo_addr <= 64'h0000_0000_0000_0000;
            finfo_index <= 16'h0000;
            finfo_write <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            mem_type <= root_r[`GECF_MT_MSB:`GECF_MT_LSB]; // [R1]
            walk_levels <= root_r[`GECF_WALK_MSB:`GECF_WALK_LSB] + 3'h1; // [R2]
            ad_flags_en <= root_r[`GECF_AD_BIT]; // [R3]
            top_table_addr <= root_r & ~root_rsv_mask &
                              ~64'h0000_0000_0000_0fff; // [R4]
            proc_tag <= tag_r; // [R6]
            root_invalid <= (HAS_NESTED != 0) &&
                            (!mt_ok || (root_r & root_rsv_mask) != 64'h0); // [R18]
            entry_fail <= (func_r[63:1] != 63'h0) ||
                          ((HAS_NESTED != 0) && (!mt_ok ||
                          (root_r & root_rsv_mask) != 64'h0)); // [R11]
            switch_en <= func_r[`GECF_FUNC_SWITCH_BIT]; // [R10]
            list_entry_addr <= {list_r[63:12], switch_idx, 3'h0}; // [R12]
            rd_bitmap_byte_addr <= rdbm_r + {52'h0, bitmap_idx[14:3]}; // [R13]
            wr_bitmap_byte_addr <= wrbm_r + {52'h0, bitmap_idx[14:3]};
            bitmap_bit <= bitmap_idx[2:0];
            bitmap_valid <= shadowing_en; // [R13]
            ssave_exit <= ssave_en && ssx_r[ssave_idx]; // [R17]
            finfo_write <= vfault; // [R14]
            finfo_addr <= finfo_r; // [R14]
            if (vfault && vfault_nested) begin
                finfo_index <= index_r; // [R15]
            end
            irq <= |((status_r | evt) & mask_r);
        end
    end
endmodule // gecf_bank

// [sim/gecf_bank_properties.sv]
// Concurrent checks on the guest execution-control bank ports
module gecf_bank_props #(
    parameter PA_WIDTH = 52
) (
    // Clock, reset and bus
    input wire clk_sys,
    input wire rst_n,
    input wire clk_en,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Side inputs
    input wire [8:0] switch_idx,
    input wire [14:0] bitmap_idx,
    input wire shadowing_en,
    input wire ssave_en,
    input wire vfault,
    // Decoded outputs
    input wire [2:0] mem_type,
    input wire [63:0] top_table_addr,
    input wire root_invalid,
    input wire entry_fail,
    input wire [63:0] list_entry_addr,
    input wire [2:0] bitmap_bit,
    input wire bitmap_valid,
    input wire ssave_exit,
    input wire finfo_write
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence rd_unmapped;
        hsel && hready && htrans[1] && !hwrite && clk_en && haddr > 12'h057;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered an error");
    a_type_check: assert property (mem_type != 3'h0 && mem_type != 3'h6 |-> root_invalid)
        else $error("reserved memory type not flagged");
    a_fail_follows: assert property (root_invalid |-> entry_fail)
        else $error("invalid root does not block entry");
    a_table_align: assert property (top_table_addr[11:0] == 12'h000 && (top_table_addr >> PA_WIDTH) == 64'h0)
        else $error("table address carries reserved bits");
    a_list_entry: assert property ($past(rst_n) |-> list_entry_addr[11:0] == {$past(switch_idx), 3'h0})
        else $error("list entry address wrong");
    a_bitmap_bit: assert property ($past(rst_n) |-> {12'h000, bitmap_bit} == ($past(bitmap_idx) & 15'h0007))
        else $error("bitmap bit select wrong");
    a_shadow_gate: assert property ($past(rst_n) |-> bitmap_valid == $past(shadowing_en))
        else $error("bitmap use not gated by shadowing");
    a_fault_store: assert property (vfault |=> finfo_write)
        else $error("fault did not store information");
    a_unmapped_read: assert property (rd_unmapped |=> hrdata == 32'h0)
        else $error("unmapped read returned data");
    a_ssave_off: assert property (!ssave_en |=> !ssave_exit)
        else $error("save bitmap consulted while disabled");
endmodule // gecf_bank_props

bind gecf_bank gecf_bank_props #(.PA_WIDTH(PA_WIDTH)) u_props (.*);

// [sim/gecf_bank_tb.sv]
// Self-checking bench for the guest execution-control bank
`include "gecf_defs.vh"
module gecf_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, clk_en, hsel, hwrite, ts_tick, spin_hint, switch_req, shadowing_en;
    logic ssave_en, vfault, vfault_nested, hreadyout, hresp, ad_flags_en, root_invalid;
    logic entry_fail, switch_en, bitmap_valid, ssave_exit, finfo_write, spin_exit, irq;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, mem_type, walk_levels, bitmap_bit;
    logic [31:0] hwdata, hrdata, rd;
    logic [8:0] switch_idx;
    logic [14:0] bitmap_idx;
    logic [5:0] ssave_idx;
    logic [15:0] proc_tag, finfo_index;
    logic [63:0] top_table_addr, list_entry_addr, rd_bitmap_byte_addr;
    logic [63:0] wr_bitmap_byte_addr, finfo_addr;
    logic [11:0] offs [12] = '{`GECF_OFF_TAG, `GECF_OFF_GAP, `GECF_OFF_WIN, `GECF_OFF_LIST_LO,
        `GECF_OFF_LIST_HI, `GECF_OFF_RDBM_LO, `GECF_OFF_WRBM_HI, `GECF_OFF_FINFO_LO,
        `GECF_OFF_FINFO_HI, `GECF_OFF_INDEX, `GECF_OFF_SSX_LO, `GECF_OFF_SSX_HI};
    int err_count, num_checks, k;
    wire hready = hreadyout;

    gecf_bank #(.PA_WIDTH(52), .HAS_NESTED(1), .HAS_TAG(1)) DUT (.*);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys);
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        {rst_n, hsel, hwrite, ts_tick, spin_hint, switch_req, shadowing_en, ssave_en} = '0;
        {vfault, vfault_nested, haddr, htrans, hwdata, switch_idx, bitmap_idx, ssave_idx} = '0;
        hsize = 3'h2;
        clk_en = 1'b1;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("walk_levels", walk_levels, 1);
        chk("irq", irq, 0);
        for (k = 0; k < 8; k++) begin
            bus(1'b1, `GECF_OFF_ROOT_LO, 32'((k % 7) << 3 | k | (k % 2) << 6));
            settle();
            chk("mem_type", mem_type, k);
            chk("walk_levels", walk_levels, k % 7 + 1);
            chk("ad_flags_en", ad_flags_en, k % 2);
            chk("root_invalid", root_invalid, k != 0 && k != 6);
            chk("entry_fail", entry_fail, k != 0 && k != 6);
        end
        bus(1'b1, `GECF_OFF_ROOT_HI, 32'h001f_ffff);
        bus(1'b1, `GECF_OFF_ROOT_LO, 32'h1234_5f06);
        settle();
        chk("top_table_addr", top_table_addr, 64'h000f_ffff_1234_5000);
        chk("root_invalid", root_invalid, 1);
        bus(1'b1, `GECF_OFF_ROOT_HI, 32'h000f_ffff);
        bus(1'b1, `GECF_OFF_ROOT_LO, 32'h1234_5046);
        settle();
        chk("root_invalid", root_invalid, 0);
        rdc("root_hi", `GECF_OFF_ROOT_HI, 32'h000f_ffff);
        for (k = 0; k < 12; k++) begin
            bus(1'b1, offs[k], 32'hc3a5_5a00 | 32'(k));
            rdc("field", offs[k], (32'hc3a5_5a00 | 32'(k)) & ((k == 0 || k == 9) ? 32'hffff : '1));
        end
        chk("proc_tag", proc_tag, 16'h5a00);
        bus(1'b1, 12'h0fc, 32'hffff_ffff);
        rdc("unmapped", 12'h0fc, 32'h0);
        bus(1'b1, `GECF_OFF_FUNC_HI, 32'h0);
        bus(1'b1, `GECF_OFF_FUNC_LO, 32'h1);
        settle();
        chk("switch_en", switch_en, 1);
        chk("entry_fail", entry_fail, 0);
        bus(1'b1, `GECF_OFF_FUNC_HI, 32'h8000_0000);
        settle();
        chk("entry_fail", entry_fail, 1);
        bus(1'b1, `GECF_OFF_FUNC_HI, 32'h0);
        bus(1'b1, `GECF_OFF_FUNC_LO, 32'h2);
        switch_idx <= 9'h1ff;
        settle();
        chk("entry_fail", entry_fail, 1);
        chk("switch_en", switch_en, 0);
        chk("list_entry", list_entry_addr, 64'hc3a5_5a04_c3a5_5ff8);
        bus(1'b1, `GECF_OFF_FUNC_LO, 32'h1);
        settle();
        chk("switch_en", switch_en, 1);
        switch_req <= 1'b1;
        @(posedge clk_sys);
        switch_req <= 1'b0;
        rdc("pointer_index", `GECF_OFF_INDEX, 32'h1ff);
        vfault <= 1'b1;
        vfault_nested <= 1'b1;
        @(posedge clk_sys);
        vfault <= 1'b0;
        @(posedge clk_sys);
        chk("finfo_write", finfo_write, 1);
        chk("finfo_addr", finfo_addr, 64'hc3a5_5a08_c3a5_5a07);
        chk("finfo_index", finfo_index, 16'h01ff);
        bitmap_idx <= 15'h7fff;
        shadowing_en <= 1'b1;
        ssave_en <= 1'b1;
        ssave_idx <= 6'h01;
        settle();
        chk("rd_bitmap", rd_bitmap_byte_addr, 64'h0000_0000_c3a5_6a04);
        chk("wr_bitmap", wr_bitmap_byte_addr, 64'hc3a5_5a06_0000_0fff);
        chk("bitmap_bit", bitmap_bit, 7);
        chk("bitmap_valid", bitmap_valid, 1);
        chk("ssave_exit", ssave_exit, 1);
        ssave_idx <= 6'h00;
        shadowing_en <= 1'b0;
        settle();
        chk("ssave_exit", ssave_exit, 0);
        chk("bitmap_valid", bitmap_valid, 0);
        ssave_en <= 1'b0;
        ssave_idx <= 6'h3f;
        settle();
        chk("ssave_exit", ssave_exit, 0);
        bus(1'b1, `GECF_OFF_GAP, 32'h3);
        bus(1'b1, `GECF_OFF_WIN, 32'ha);
        bus(1'b1, `GECF_OFF_MASK, 32'h0);
        bus(1'b0, `GECF_OFF_STATUS, 32'h0);
        k = 0;
        do begin
            ts_tick <= 1'b1;
            spin_hint <= k % 2 == 0;
            @(posedge clk_sys);
            k++;
        end while (spin_exit !== 1'b1 && k < 60);
        ts_tick <= 1'b0;
        spin_hint <= 1'b0;
        chk("window_ticks", k >= 10 && k <= 14, 1);
        rdc("status", `GECF_OFF_STATUS, 32'h2);
        spin_hint <= 1'b1;
        @(posedge clk_sys);
        spin_hint <= 1'b0;
        ts_tick <= 1'b1;
        repeat (5) @(posedge clk_sys);
        ts_tick <= 1'b0;
        spin_hint <= 1'b1;
        @(posedge clk_sys);
        spin_hint <= 1'b0;
        settle();
        chk("irq", irq, 0);
        bus(1'b1, `GECF_OFF_MASK, 32'h1);
        settle();
        chk("irq", irq, 1);
        rdc("status", `GECF_OFF_STATUS, 32'h1);
        settle();
        chk("irq", irq, 0);
        stop_test();
    end
endmodule // gecf_bank_tb
